/* File: pkg/ana_pkg.sv */
/*
  Constants, register map and state encoding of the auto-negotiation
  ability register bank.
  Assumes a single 100 MHz management clock and APB access with 32-bit
  data, one register per aligned word, byte address four times the index.
*/
package ana_pkg;

  // Bus geometry.
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned REG_DW = 16;

  // Register indices and their byte addresses.
  localparam logic [3:0]        IDX_BASIC_STATUS = 4'h1;
  localparam logic [3:0]        IDX_ADVERT       = 4'h4;
  localparam logic [3:0]        IDX_PARTNER      = 4'h5;
  localparam logic [3:0]        IDX_EXPANSION    = 4'h6;
  localparam logic [3:0]        IDX_NP_RX        = 4'h8;
  localparam logic [APB_AW-1:0] ADDR_BASIC_STATUS = {6'h00, IDX_BASIC_STATUS, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_ADVERT       = {6'h00, IDX_ADVERT, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_PARTNER      = {6'h00, IDX_PARTNER, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_EXPANSION    = {6'h00, IDX_EXPANSION, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_NP_RX        = {6'h00, IDX_NP_RX, 2'h0};

  // Reset values.
  localparam logic [REG_DW-1:0] ADVERT_RST    = 16'h01e1;
  localparam logic [REG_DW-1:0] PARTNER_RST   = 16'h0000;
  localparam logic [REG_DW-1:0] EXPANSION_RST = 16'h0064;
  localparam logic [REG_DW-1:0] NP_RX_RST     = 16'h2001;

  // Writable bits of the advertisement word: all but bit 14.
  localparam logic [REG_DW-1:0] ADVERT_WMASK  = 16'hbfff;
  // Bits the partner word may hold: all but bit 12.
  localparam logic [REG_DW-1:0] PARTNER_MASK  = 16'hefff;

  // Advertisement and partner field positions.
  localparam int unsigned BIT_NP        = 15;
  localparam int unsigned BIT_RSV14     = 14;
  localparam int unsigned BIT_RF        = 13;
  localparam int unsigned BIT_RSV12     = 12;
  localparam int unsigned BIT_ASYM      = 11;
  localparam int unsigned BIT_SYM       = 10;
  localparam int unsigned BIT_T4        = 9;
  localparam int unsigned SPEED_LSB     = 5;
  localparam int unsigned SPEED_W       = 4;
  localparam int unsigned SEL_MSB       = 4;
  localparam int unsigned SEL_LSB       = 0;

  // Expansion and basic status field positions.
  localparam int unsigned EXP_LOC_ABLE  = 6;
  localparam int unsigned EXP_STORAGE   = 5;
  localparam int unsigned EXP_PD_FAULT  = 4;
  localparam int unsigned BS_NEG_DONE   = 5;

  // Strap capture: cycles allowed for the pin synchroniser to fill.
  localparam logic [1:0]  STRAP_SETTLE  = 2'h3;
  localparam logic [SPEED_W-1:0] STRAP_DEFAULT = 4'hf;

  // Strap capture sequence.
  typedef enum logic [2:0] {
    ANA_ST_SETTLE = 3'b001,
    ANA_ST_LOAD   = 3'b010,
    ANA_ST_RUN    = 3'b100
  } ana_strap_e;

endpackage

/* File: verilog/ana_pin_sync.sv */
/*
  Three-flop synchroniser for the speed strap pins.
  Assumes the pins are static or slow relative to pclk; pin_sync follows
  the third flop, and pin_agree flags bits where the second and third flops agree.
*/
`timescale 1ns/100ps
module ana_pin_sync
  import ana_pkg::*;
(
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Asynchronous pins.
  input  wire logic [SPEED_W-1:0] pin_in,
  // Synchronised result.
  output logic      [SPEED_W-1:0] pin_sync,
  output logic      [SPEED_W-1:0] pin_agree
);

  logic [SPEED_W-1:0] s1_q;
  logic [SPEED_W-1:0] s2_q;
  logic [SPEED_W-1:0] s3_q;
  logic [SPEED_W-1:0] s1_d;
  logic [SPEED_W-1:0] s2_d;
  logic [SPEED_W-1:0] s3_d;

  // Shift chain; the first stage feeds only the second.
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Flops reset to the no-strap default so an unfilled chain looks benign.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= STRAP_DEFAULT;
      s2_q <= STRAP_DEFAULT;
      s3_q <= STRAP_DEFAULT;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // Per-bit agreement between the two settled stages.
  genvar gi;
  generate
    for (gi = 0; gi < SPEED_W; gi++) begin : g_agree
      assign pin_agree[gi] = ~(s2_q[gi] ^ s3_q[gi]);
    end
  endgenerate

  assign pin_sync = s3_q;

endmodule // ana_pin_sync

/* File: verilog/ana_ability_regs.sv */
/*
  Auto-negotiation ability register bank: local advertisement, partner
  base page, expansion status, negotiation-done status and received
  next page, reached over an APB slave with zero wait states.
  Assumes the negotiation engine runs on pclk and presents single-cycle
  page pulses; strap pins are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
module ana_ability_regs
  import ana_pkg::*;
(
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [APB_AW-1:0]  paddr,
  input  wire logic [APB_DW-1:0]  pwdata,
  output logic      [APB_DW-1:0]  prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Strap pins: fast full, fast half, ten full, ten half (msb first).
  input  wire logic [SPEED_W-1:0] strap_speed,
  // Negotiation engine status and received pages.
  input  wire logic               negotiation_done,
  input  wire logic               page_rx_valid,
  input  wire logic               page_rx_next,
  input  wire logic [REG_DW-1:0]  page_rx_data,
  input  wire logic               parallel_detect_fault,
  // Base page to transmit.
  output logic      [REG_DW-1:0]  adv_page
);

  // Bus decode.
  logic               setup_rd;
  logic               access_wr;
  logic               access_rd;
  logic               addr_hit;
  logic [REG_DW-1:0]  wdata16;

  // Strap capture.
  ana_strap_e         strap_st_q;
  ana_strap_e         strap_st_d;
  logic [1:0]         settle_q;
  logic [1:0]         settle_d;
  logic [SPEED_W-1:0] strap_sync;
  logic [SPEED_W-1:0] strap_agree;

  // Register state.
  logic [REG_DW-1:0]  advert_q;
  logic [REG_DW-1:0]  advert_d;
  logic [REG_DW-1:0]  partner_q;
  logic [REG_DW-1:0]  partner_d;
  logic [REG_DW-1:0]  np_rx_q;
  logic [REG_DW-1:0]  np_rx_d;
  logic               pd_fault_q;
  logic               pd_fault_d;
  logic               done_q;
  logic               done_d;
  logic [APB_DW-1:0]  prdata_q;
  logic [APB_DW-1:0]  prdata_d;
  logic               slverr_q;
  logic               slverr_d;
  logic [REG_DW-1:0]  rd_word;
  logic [REG_DW-1:0]  expansion_word;
  logic [REG_DW-1:0]  status_word;

  // Strap pins pass the three-flop synchroniser before any use.
  ana_pin_sync u_strap_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (strap_speed),
    .pin_sync  (strap_sync),
    .pin_agree (strap_agree)
  );

  // APB phase decode; the slave never inserts wait states.
  always_comb begin
    setup_rd  = psel & ~penable & ~pwrite;
    access_wr = psel & penable & pwrite;
    access_rd = psel & penable & ~pwrite;
    wdata16   = pwdata[REG_DW-1:0];
    addr_hit  = (paddr == ADDR_BASIC_STATUS) | (paddr == ADDR_ADVERT) |
                (paddr == ADDR_PARTNER) | (paddr == ADDR_EXPANSION) |
                (paddr == ADDR_NP_RX);
  end

  assign pready = 1'b1;

  // Strap capture: wait for the synchroniser to fill, then load once when
  // both settled stages agree, so a pin still moving is not taken.
  always_comb begin
    strap_st_d = strap_st_q;
    settle_d   = settle_q;
    case (strap_st_q)
      ANA_ST_SETTLE: begin
        if (settle_q == STRAP_SETTLE) begin
          strap_st_d = ANA_ST_LOAD;
        end else begin
          settle_d = settle_q + 2'h1;
        end
      end
      ANA_ST_LOAD: begin
        if (&strap_agree) begin
          strap_st_d = ANA_ST_RUN;
        end
      end
      ANA_ST_RUN: begin
        strap_st_d = ANA_ST_RUN;
      end
      default: begin
        strap_st_d = ANA_ST_SETTLE;
        settle_d   = 2'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_st_q <= ANA_ST_SETTLE;
      settle_q   <= 2'h0;
    end else begin
      strap_st_q <= strap_st_d;
      settle_q   <= settle_d;
    end
  end

  // Advertisement word. Bit 14 is held at zero; a software write in the
  // strap load cycle wins, as it is the later intent.
  always_comb begin
    advert_d = advert_q;
    if ((strap_st_q == ANA_ST_LOAD) && (&strap_agree)) begin
      advert_d[SPEED_LSB +: SPEED_W] = strap_sync;
    end
    if (access_wr && (paddr == ADDR_ADVERT)) begin
      advert_d = wdata16 & ADVERT_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      advert_q <= ADVERT_RST;
    end else begin
      advert_q <= advert_d;
    end
  end

  // The transmitted base page is the register itself; a write reaches
  // adv_page on the next cycle, whether or not negotiation is done.
  assign adv_page = advert_q;

  // Received pages: base pages land in the partner word, next pages in the
  // dedicated next-page register, since storage select reads as one.
  always_comb begin
    partner_d = partner_q;
    np_rx_d   = np_rx_q;
    if (page_rx_valid && !page_rx_next) begin
      partner_d = page_rx_data & PARTNER_MASK;
    end
    if (page_rx_valid && page_rx_next) begin
      np_rx_d = page_rx_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_q <= PARTNER_RST;
      np_rx_q   <= NP_RX_RST;
    end else begin
      partner_q <= partner_d;
      np_rx_q   <= np_rx_d;
    end
  end

  // Parallel detection fault latch. Only a fault that software actually
  // saw in the read data is cleared, so one arriving between setup and
  // access survives; a new fault in the clearing cycle wins as well.
  always_comb begin
    pd_fault_d = pd_fault_q;
    if (access_rd && (paddr == ADDR_EXPANSION) && prdata_q[EXP_PD_FAULT]) begin
      pd_fault_d = 1'b0;
    end
    if (parallel_detect_fault) begin
      pd_fault_d = 1'b1;
    end
    done_d = negotiation_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_fault_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      pd_fault_q <= pd_fault_d;
      done_q     <= done_d;
    end
  end

  // Composite read words; everything not named reads as zero.
  always_comb begin
    expansion_word               = '0;
    expansion_word[EXP_LOC_ABLE] = EXPANSION_RST[EXP_LOC_ABLE];
    expansion_word[EXP_STORAGE]  = EXPANSION_RST[EXP_STORAGE];
    expansion_word[EXP_PD_FAULT] = pd_fault_q;
    status_word                  = '0;
    status_word[BS_NEG_DONE]     = done_q;
  end

  // Read data and error are prepared in the setup phase so the access
  // phase answers from flops; unmapped addresses answer with an error.
  always_comb begin
    case (paddr)
      ADDR_BASIC_STATUS: rd_word = status_word;
      ADDR_ADVERT:       rd_word = advert_q;
      ADDR_PARTNER:      rd_word = partner_q;
      ADDR_EXPANSION:    rd_word = expansion_word;
      ADDR_NP_RX:        rd_word = np_rx_q;
      default:           rd_word = '0;
    endcase
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    if (psel && !penable) begin
      prdata_d = '0;
      slverr_d = ~addr_hit;
      if (setup_rd) begin
        prdata_d[REG_DW-1:0] = rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = slverr_q & psel & penable;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A write reaches the transmitted page on the next cycle, bit 14 clear.
  property p_adv_write;
    access_wr && (paddr == ADDR_ADVERT) |=> adv_page == ($past(pwdata[REG_DW-1:0]) & ADVERT_WMASK);
  endproperty
  a_adv_write: assert property (p_adv_write) else $error("advert write not applied");

  property p_adv_rsv;
    !adv_page[BIT_RSV14];
  endproperty
  a_adv_rsv: assert property (p_adv_rsv) else $error("advert bit 14 set");

  // The strap value is loaded in the cycle after the load state accepts it.
  property p_strap_load;
    (strap_st_q == ANA_ST_LOAD) && (&strap_agree) && !access_wr
      |=> adv_page[SPEED_LSB +: SPEED_W] == $past(strap_sync);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

  property p_base_page;
    page_rx_valid && !page_rx_next
      |=> partner_q == ($past(page_rx_data) & PARTNER_MASK) && !partner_q[BIT_RSV12];
  endproperty
  a_base_page: assert property (p_base_page) else $error("base page not stored");

  property p_next_page;
    page_rx_valid && page_rx_next |=> np_rx_q == $past(page_rx_data) && $stable(partner_q);
  endproperty
  a_next_page: assert property (p_next_page) else $error("next page misplaced");

  property p_fault_set;
    parallel_detect_fault |=> pd_fault_q [*1] ##1 (pd_fault_q || $past(access_rd));
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_fault_hold;
    pd_fault_q && !(access_rd && (paddr == ADDR_EXPANSION)) |=> pd_fault_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault lost without read");

  property p_fault_clear;
    access_rd && (paddr == ADDR_EXPANSION) && prdata[EXP_PD_FAULT] && !parallel_detect_fault
      |=> !pd_fault_q;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

  property p_exp_read;
    setup_rd && (paddr == ADDR_EXPANSION)
      |=> prdata[EXP_LOC_ABLE] && prdata[EXP_STORAGE] && (prdata[REG_DW-1:7] == '0);
  endproperty
  a_exp_read: assert property (p_exp_read) else $error("expansion constant bits wrong");

  property p_done_read;
    setup_rd && (paddr == ADDR_BASIC_STATUS) ##1 1'b1
      |-> prdata[BS_NEG_DONE] == $past(negotiation_done, 2);
  endproperty
  a_done_read: assert property (p_done_read) else $error("done bit wrong");

endmodule // ana_ability_regs

/* File: tb/ana_link_partner.sv */
/*
  Behavioural stand-in for the negotiation engine and the remote partner.
  Assumes the bench calls its tasks from one process, one page at a time.
*/
`timescale 1ns/100ps
module ana_link_partner
  import ana_pkg::*;
(
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Results handed to the register bank.
  output logic               negotiation_done,
  output logic               page_rx_valid,
  output logic               page_rx_next,
  output logic [REG_DW-1:0]  page_rx_data,
  output logic               parallel_detect_fault
);
  // Quiet engine at time zero.
  initial begin
    negotiation_done      = 1'b0;
    page_rx_valid         = 1'b0;
    page_rx_next          = 1'b0;
    page_rx_data          = 16'h0000;
    parallel_detect_fault = 1'b0;
  end

  // One-cycle page; data is scrambled once it is no longer valid.
  task automatic send_page(input logic nxt, input logic [REG_DW-1:0] d);
    @(posedge pclk);
    page_rx_valid <= 1'b1;
    page_rx_next  <= nxt;
    page_rx_data  <= d;
    @(posedge pclk);
    page_rx_valid <= 1'b0;
    page_rx_data  <= ~d;
  endtask

  // Level of the completion flag.
  task automatic set_done(input logic v);
    @(posedge pclk);
    negotiation_done <= v;
  endtask

  // Single-cycle parallel detection fault.
  task automatic pulse_fault();
    @(posedge pclk);
    parallel_detect_fault <= 1'b1;
    @(posedge pclk);
    parallel_detect_fault <= 1'b0;
  endtask
endmodule // ana_link_partner

/* File: tb/testbench.sv */
/*
  Self-checking bench of the ability register bank, APB master and model.
  Assumes zero-wait APB but waits on pready under a bound anyway.
*/
`timescale 1ns/100ps
module testbench;
  import ana_pkg::*;

  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [APB_AW-1:0]  paddr;
  logic [APB_DW-1:0]  pwdata;
  logic [APB_DW-1:0]  prdata;
  logic               pready;
  logic               pslverr;
  logic [SPEED_W-1:0] strap_speed;
  logic               negotiation_done;
  logic               page_rx_valid;
  logic               page_rx_next;
  logic [REG_DW-1:0]  page_rx_data;
  logic               parallel_detect_fault;
  logic [REG_DW-1:0]  adv_page;
  int                 n_fail;
  int                 num_checks;
  int                 m_adv;
  int                 m_par;
  int                 m_np;
  int                 q_np[$];
  logic [31:0]        r;
  logic [15:0]        d;

  ana_ability_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_speed(strap_speed), .negotiation_done(negotiation_done),
    .page_rx_valid(page_rx_valid), .page_rx_next(page_rx_next),
    .page_rx_data(page_rx_data), .parallel_detect_fault(parallel_detect_fault),
    .adv_page(adv_page));

  ana_link_partner partner (.pclk(pclk), .presetn(presetn),
    .negotiation_done(negotiation_done), .page_rx_valid(page_rx_valid),
    .page_rx_next(page_rx_next), .page_rx_data(page_rx_data),
    .parallel_detect_fault(parallel_detect_fault));

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  // Verdict and end of run.
  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Single compare for every register-sized result.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare data and error flag.
  task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] v;
    logic        er;
    apb(1'b0, a, $urandom, v, er);
    chk("prdata", e, v);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask

  // Write and compare the error flag.
  task automatic wr_chk(input logic [APB_AW-1:0] a, input logic [31:0] wd, input logic ee);
    logic [31:0] v;
    logic        er;
    apb(1'b1, a, wd, v, er);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask

  // Reset held for eight cycles; the model returns to its reset picture.
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("adv_page", 32'h01e1, {16'h0, adv_page});
    presetn <= 1'b1;
    m_adv = 32'h0001 | (int'(strap_speed) << 5);
    m_par = 0;
    m_np  = 32'h2001;
    repeat (12) @(posedge pclk);
  endtask

  // Main sequence.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(75194));
    strap_speed = 4'($urandom);
    do_reset();
    // Reset values of every register, straps folded into the speed bits.
    rd_chk(ADDR_ADVERT, m_adv, 1'b0);
    chk("adv_page", m_adv, {16'h0, adv_page});
    rd_chk(ADDR_PARTNER, m_par, 1'b0);
    rd_chk(ADDR_EXPANSION, 32'h0060, 1'b0);
    rd_chk(ADDR_NP_RX, m_np, 1'b0);
    rd_chk(ADDR_BASIC_STATUS, 32'h0, 1'b0);
    // Random advertisements; bit 14 and upper half never stick.
    repeat (4) begin
      r = $urandom;
      wr_chk(ADDR_ADVERT, r, 1'b0);
      m_adv = int'(r[15:0] & 16'hbfff);
      rd_chk(ADDR_ADVERT, m_adv, 1'b0);
      chk("adv_page", m_adv, {16'h0, adv_page});
    end
    // Read-only and reserved places refuse writes; unmapped address errors.
    wr_chk(ADDR_PARTNER, 32'hffffffff, 1'b0);
    wr_chk(ADDR_EXPANSION, 32'hffffffff, 1'b0);
    rd_chk(ADDR_PARTNER, m_par, 1'b0);
    rd_chk(ADDR_EXPANSION, 32'h0060, 1'b0);
    wr_chk(12'h03c, 32'h0000ffff, 1'b1);
    rd_chk(12'h03c, 32'h0, 1'b1);
    rd_chk(ADDR_ADVERT, m_adv, 1'b0);
    // Renegotiation after the writes: the partner sends fresh base pages,
    // reserved bit 12 forced low.
    repeat (3) begin
      d = 16'($urandom);
      partner.send_page(1'b0, d);
      m_par = int'(d & 16'hefff);
      rd_chk(ADDR_PARTNER, m_par, 1'b0);
    end
    // Completion, then next pages land in register 8 only.
    partner.set_done(1'b1);
    rd_chk(ADDR_BASIC_STATUS, 32'h0020, 1'b0);
    repeat (2) begin
      d = 16'($urandom);
      q_np.push_back(int'(d));
      partner.send_page(1'b1, d);
      m_np = q_np.pop_front();
      rd_chk(ADDR_NP_RX, m_np, 1'b0);
      rd_chk(ADDR_PARTNER, m_par, 1'b0);
    end
    partner.set_done(1'b0);
    rd_chk(ADDR_BASIC_STATUS, 32'h0, 1'b0);
    // Fault latch holds across idle time and clears on its read.
    partner.pulse_fault();
    repeat (5) @(posedge pclk);
    rd_chk(ADDR_EXPANSION, 32'h0070, 1'b0);
    rd_chk(ADDR_EXPANSION, 32'h0060, 1'b0);
    // Second reset in mid-run restores straps and clears the partner word.
    strap_speed <= 4'($urandom);
    do_reset();
    rd_chk(ADDR_ADVERT, m_adv, 1'b0);
    chk("adv_page", m_adv, {16'h0, adv_page});
    rd_chk(ADDR_PARTNER, m_par, 1'b0);
    rd_chk(ADDR_NP_RX, m_np, 1'b0);
    complete_run();
  end
endmodule // testbench
